// ==== sect_core_timing.v ====
// Sequencer of a small non-pipelined core: fetch, execute, data transfer, retire.
// Assumes a register file outside that presents op_a/op_b from instr_word one cycle after fetch,
// and bus slaves that answer with waitrequest low in the cycle the data is valid.
//
// Contract
// - No multiply or divide hardware; such instructions raise unimplemented exception.
// - Shifts and rotates move one bit per clock; 7 to 38 cycles total.
// - No caches; every fetch and data access is a bus transfer.
// - Data address bit 31 always zero; 2 Gbyte reach, no bypass meaning.
// - One instruction at a time; next fetch only after completion.
// - No branch prediction; next fetch address resolved after completion.
// - Six cycles minimum, only when fetch completes in one cycle.
// - Every fetch wait cycle lengthens the instruction by one cycle.
// - ALU, control flow, traps, control and other instructions take six cycles.
// - Word load takes six cycles plus read transfer duration.
// - Halfword load takes nine cycles plus read transfer duration.
// - Byte load takes ten cycles plus read transfer duration.
// - Store takes six cycles plus write transfer duration.
// - Multi-cycle custom takes at least six cycles, waits for custom done.
// - Exceptions come from hardware interrupt, trap, or unimplemented instruction.
// - Debug link may halt the core; no hardware breakpoints, no trace.
// - Undefined opcodes need no detection; behaviour is then unspecified.
`default_nettype none
`include "sect_defs.vh"

module sect_core_timing
(
	// Clock and reset
	input  wire        clock,
	input  wire        rstn,
	// Instruction master port
	output wire        ibus_read,
	output wire [31:0] ibus_address,
	input  wire        ibus_waitrequest,
	input  wire [31:0] ibus_readdata,
	// Data master port
	output wire        dbus_read,
	output wire        dbus_write,
	output wire [31:0] dbus_address,
	output wire [3:0]  dbus_byteenable,
	output wire [31:0] dbus_writedata,
	input  wire        dbus_waitrequest,
	input  wire [31:0] dbus_readdata,
	// Register file side
	output wire [31:0] instr_word,
	input  wire [31:0] op_a,
	input  wire [31:0] op_b,
	output wire        retire,
	output wire        wb_en,
	output wire [31:0] wb_data,
	// Custom instruction logic
	output wire        ci_start,
	input  wire        ci_done,
	input  wire [31:0] ci_result,
	// Exceptions
	input  wire        irq,
	input  wire        irq_enable,
	output wire        exc_valid,
	output wire [1:0]  exc_cause,
	output wire [31:0] exc_return,
	// Debug module
	input  wire        dbg_halt_req,
	output wire        dbg_halted
);

	localparam [2:0] S_FETCH  = 3'h0;
	localparam [2:0] S_PRE    = 3'h1;
	localparam [2:0] S_XFER   = 3'h2;
	localparam [2:0] S_EXTR   = 3'h3;
	localparam [2:0] S_SHIFT  = 3'h4;
	localparam [2:0] S_CWAIT  = 3'h5;
	localparam [2:0] S_RETIRE = 3'h6;
	localparam [2:0] S_HALT   = 3'h7;

	reg [2:0]  state_reg;
	reg [2:0]  cnt_reg;
	reg [31:0] pc_reg;
	reg [31:0] ir_reg;
	reg        ibus_read_reg;
	reg        dbus_read_reg;
	reg        dbus_write_reg;
	reg [31:0] dbus_address_reg;
	reg [3:0]  dbus_byteenable_reg;
	reg [31:0] dbus_writedata_reg;
	reg [31:0] ldata_reg;
	reg [31:0] res_reg;
	reg        ci_start_reg;
	reg        ci_seen_reg;
	reg        retire_reg;
	reg        wb_en_reg;
	reg [31:0] wb_data_reg;
	reg        exc_valid_reg;
	reg [1:0]  exc_cause_reg;
	reg [31:0] exc_return_reg;
	reg        dbg_halted_reg;

	wire [3:0]  cls    = ir_reg[`SECT_CLASS_HI:`SECT_CLASS_LO];
	wire [3:0]  subop  = ir_reg[`SECT_SUBOP_HI:`SECT_SUBOP_LO];
	wire [31:0] imm    = {{16{ir_reg[`SECT_IMM_HI]}}, ir_reg[`SECT_IMM_HI:`SECT_IMM_LO]};
	wire [31:0] pc_inc = pc_reg + 32'h00000004;
	wire [31:0] ea     = (op_a + imm) & `SECT_ADDR_MASK;
	wire        is_load  = (cls == `SECT_CL_LDW) || (cls == `SECT_CL_LDH) || (cls == `SECT_CL_LDB);
	wire        is_store = (cls == `SECT_CL_STORE);
	wire        sh_busy;
	wire        sh_last;
	wire [31:0] sh_result;
	wire        sh_load = (state_reg == S_PRE) && (cnt_reg == 3'h0) && (cls == `SECT_CL_SHIFT);

	reg [31:0] alu_res;
	reg [31:0] ext_res;
	reg [31:0] next_pc;
	reg [3:0]  lane_be;

	assign ibus_read       = ibus_read_reg;
	assign ibus_address    = pc_reg;
	assign dbus_read       = dbus_read_reg;
	assign dbus_write      = dbus_write_reg;
	assign dbus_address    = dbus_address_reg;
	assign dbus_byteenable = dbus_byteenable_reg;
	assign dbus_writedata  = dbus_writedata_reg;
	assign instr_word      = ir_reg;
	assign retire          = retire_reg;
	assign wb_en           = wb_en_reg;
	assign wb_data         = wb_data_reg;
	assign ci_start        = ci_start_reg;
	assign exc_valid       = exc_valid_reg;
	assign exc_cause       = exc_cause_reg;
	assign exc_return      = exc_return_reg;
	assign dbg_halted      = dbg_halted_reg;

	sect_shifter u_shifter
	(
		.clock  (clock),
		.rstn   (rstn),
		.load   (sh_load),
		.value  (op_a),
		.amount (op_b[4:0]),
		.kind   (ir_reg[`SECT_SKIND_HI:`SECT_SKIND_LO]),
		.busy   (sh_busy),
		.last   (sh_last),
		.result (sh_result)
	);

	// Plain operations only; there is deliberately no multiplier or divider.
	always @*
	begin
		case (subop)
			`SECT_ALU_ADD:   alu_res = op_a + op_b;
			`SECT_ALU_SUB:   alu_res = op_a - op_b;
			`SECT_ALU_AND:   alu_res = op_a & op_b;
			`SECT_ALU_OR:    alu_res = op_a | op_b;
			`SECT_ALU_XOR:   alu_res = op_a ^ op_b;
			`SECT_ALU_CMPLT: alu_res = {31'h00000000, ($signed(op_a) < $signed(op_b))};
			default:         alu_res = op_a;
		endcase
	end

	// Byte lanes of a narrow load follow the low address bits.
	always @*
	begin
		case (cls)
			`SECT_CL_LDH: lane_be = ea[1] ? 4'hc : 4'h3;
			`SECT_CL_LDB: lane_be = 4'h1 << ea[1:0];
			default:      lane_be = 4'hf;
		endcase
	end

	// Extraction and sign extension of a narrow load; it is given extra cycles to settle.
	always @*
	begin
		ext_res = ldata_reg;
		if (cls == `SECT_CL_LDH)
		begin
			if (dbus_address_reg[1])
				ext_res = {{16{ldata_reg[31]}}, ldata_reg[31:16]};
			else
				ext_res = {{16{ldata_reg[15]}}, ldata_reg[15:0]};
		end
		else if (cls == `SECT_CL_LDB)
		begin
			case (dbus_address_reg[1:0])
				2'h0:    ext_res = {{24{ldata_reg[7]}}, ldata_reg[7:0]};
				2'h1:    ext_res = {{24{ldata_reg[15]}}, ldata_reg[15:8]};
				2'h2:    ext_res = {{24{ldata_reg[23]}}, ldata_reg[23:16]};
				default: ext_res = {{24{ldata_reg[31]}}, ldata_reg[31:24]};
			endcase
		end
	end

	// The successor is only known here, after the instruction has finished.
	always @*
	begin
		next_pc = pc_inc;
		if (irq && irq_enable)
			next_pc = `SECT_EXC_VECTOR;
		else if ((cls == `SECT_CL_TRAP) || (cls == `SECT_CL_UNIMPL))
			next_pc = `SECT_EXC_VECTOR;
		else if ((cls == `SECT_CL_BRANCH) && (op_a == op_b))
			next_pc = pc_inc + imm;
		else if (cls == `SECT_CL_JUMP)
			next_pc = op_a;
	end

	always @(posedge clock)
	begin
		if (!rstn)
		begin
			state_reg           <= S_FETCH;
			cnt_reg             <= 3'h0;
			pc_reg              <= `SECT_RESET_PC;
			ir_reg              <= 32'h00000000;
			ibus_read_reg       <= 1'b0;
			dbus_read_reg       <= 1'b0;
			dbus_write_reg      <= 1'b0;
			dbus_address_reg    <= 32'h00000000;
			dbus_byteenable_reg <= 4'h0;
			dbus_writedata_reg  <= 32'h00000000;
			ldata_reg           <= 32'h00000000;
			res_reg             <= 32'h00000000;
			ci_start_reg        <= 1'b0;
			ci_seen_reg         <= 1'b0;
			retire_reg          <= 1'b0;
			wb_en_reg           <= 1'b0;
			wb_data_reg         <= 32'h00000000;
			exc_valid_reg       <= 1'b0;
			exc_cause_reg       <= 2'h0;
			exc_return_reg      <= 32'h00000000;
			dbg_halted_reg      <= 1'b0;
		end
		else
		begin
			retire_reg    <= 1'b0;
			wb_en_reg     <= 1'b0;
			exc_valid_reg <= 1'b0;
			ci_start_reg  <= 1'b0;
			// The done flag is only cleared when a new custom operation starts.
			if (ci_done)
				ci_seen_reg <= 1'b1;
			case (state_reg)
				S_FETCH:
				begin
					// Each wait cycle simply holds the sequencer here.
					ibus_read_reg <= 1'b1;
					if (ibus_read_reg && !ibus_waitrequest)
					begin
						ibus_read_reg <= 1'b0;
						ir_reg        <= ibus_readdata;
						cnt_reg       <= `SECT_PRE_CYC - 3'h1;
						state_reg     <= S_PRE;
						// A done that lands with the start is kept, so the set wins the clear.
						if (ibus_readdata[`SECT_CLASS_HI:`SECT_CLASS_LO] == `SECT_CL_CUSTM)
						begin
							ci_start_reg <= 1'b1;
							ci_seen_reg  <= ci_done;
						end
					end
				end
				S_PRE:
				begin
					if (cnt_reg != 3'h0)
						cnt_reg <= cnt_reg - 3'h1;
					else if (is_load || is_store)
					begin
						state_reg           <= S_XFER;
						dbus_read_reg       <= is_load;
						dbus_write_reg      <= is_store;
						dbus_address_reg    <= ea;
						dbus_byteenable_reg <= lane_be;
						dbus_writedata_reg  <= op_b;
					end
					else if (cls == `SECT_CL_SHIFT)
						state_reg <= S_SHIFT;
					else if ((cls == `SECT_CL_CUSTM) && !ci_seen_reg && !ci_done)
						state_reg <= S_CWAIT;
					else
					begin
						state_reg <= S_RETIRE;
						if (cls == `SECT_CL_CUSTC)
							res_reg <= ci_result;
						else if (cls == `SECT_CL_CUSTM)
							res_reg <= ci_result;
						else
							res_reg <= alu_res;
					end
				end
				S_XFER:
				begin
					if (!dbus_waitrequest)
					begin
						dbus_read_reg  <= 1'b0;
						dbus_write_reg <= 1'b0;
						ldata_reg      <= dbus_readdata;
						if (cls == `SECT_CL_LDH)
						begin
							state_reg <= S_EXTR;
							cnt_reg   <= `SECT_HALF_CYC - 3'h1;
						end
						else if (cls == `SECT_CL_LDB)
						begin
							state_reg <= S_EXTR;
							cnt_reg   <= `SECT_BYTE_CYC - 3'h1;
						end
						else
						begin
							state_reg <= S_RETIRE;
							res_reg   <= dbus_readdata;
						end
					end
				end
				S_EXTR:
				begin
					if (cnt_reg != 3'h0)
						cnt_reg <= cnt_reg - 3'h1;
					else
					begin
						state_reg <= S_RETIRE;
						res_reg   <= ext_res;
					end
				end
				S_SHIFT:
				begin
					if (sh_last)
					begin
						state_reg <= S_RETIRE;
						res_reg   <= sh_result;
					end
				end
				S_CWAIT:
				begin
					if (ci_done)
					begin
						state_reg <= S_RETIRE;
						res_reg   <= ci_result;
					end
				end
				S_RETIRE:
				begin
					retire_reg <= 1'b1;
					pc_reg     <= next_pc;
					wb_data_reg <= res_reg;
					wb_en_reg  <= (cls == `SECT_CL_ALU) || is_load || (cls == `SECT_CL_SHIFT) ||
						(cls == `SECT_CL_CUSTC) || (cls == `SECT_CL_CUSTM) || (cls == `SECT_CL_OTHER);
					if (irq && irq_enable)
					begin
						exc_valid_reg  <= 1'b1;
						exc_cause_reg  <= `SECT_EXC_IRQ;
						exc_return_reg <= pc_inc;
					end
					else if (cls == `SECT_CL_TRAP)
					begin
						exc_valid_reg  <= 1'b1;
						exc_cause_reg  <= `SECT_EXC_TRAP;
						exc_return_reg <= pc_inc;
					end
					else if (cls == `SECT_CL_UNIMPL)
					begin
						exc_valid_reg  <= 1'b1;
						exc_cause_reg  <= `SECT_EXC_UNIMPL;
						exc_return_reg <= pc_inc;
					end
					// Halting is only possible between instructions; no address is compared.
					if (dbg_halt_req)
					begin
						state_reg      <= S_HALT;
						dbg_halted_reg <= 1'b1;
					end
					else
					begin
						state_reg     <= S_FETCH;
						ibus_read_reg <= 1'b1;
					end
				end
				S_HALT:
				begin
					if (!dbg_halt_req)
					begin
						dbg_halted_reg <= 1'b0;
						state_reg      <= S_FETCH;
						ibus_read_reg  <= 1'b1;
					end
				end
				default:
					state_reg <= S_FETCH;
			endcase
		end
	end

endmodule // sect_core_timing
`default_nettype wire

// ==== sect_defs.vh ====
// Constants shared by the sequential core timing block and its serial shifter.
// Assumes a single 50 MHz core clock; the instruction field layout below is local to this block.
`ifndef SECT_DEFS_VH
`define SECT_DEFS_VH

// Instruction field positions.
`define SECT_CLASS_HI     3
`define SECT_CLASS_LO     0
`define SECT_SUBOP_HI     7
`define SECT_SUBOP_LO     4
`define SECT_SKIND_HI     9
`define SECT_SKIND_LO     8
`define SECT_IMM_HI       31
`define SECT_IMM_LO       16

// Instruction classes.
`define SECT_CL_ALU       4'h0
`define SECT_CL_BRANCH    4'h1
`define SECT_CL_JUMP      4'h2
`define SECT_CL_TRAP      4'h3
`define SECT_CL_UNIMPL    4'h4
`define SECT_CL_LDW       4'h5
`define SECT_CL_LDH       4'h6
`define SECT_CL_LDB       4'h7
`define SECT_CL_STORE     4'h8
`define SECT_CL_SHIFT     4'h9
`define SECT_CL_CUSTC     4'ha
`define SECT_CL_CUSTM     4'hb
`define SECT_CL_OTHER     4'hc

// ALU sub-operations.
`define SECT_ALU_ADD      4'h0
`define SECT_ALU_SUB      4'h1
`define SECT_ALU_AND      4'h2
`define SECT_ALU_OR       4'h3
`define SECT_ALU_XOR      4'h4
`define SECT_ALU_CMPLT    4'h5

// Shift kinds.
`define SECT_SH_SLL       2'h0
`define SECT_SH_SRL       2'h1
`define SECT_SH_SRA       2'h2
`define SECT_SH_ROL       2'h3

// Exception causes.
`define SECT_EXC_IRQ      2'h1
`define SECT_EXC_TRAP     2'h2
`define SECT_EXC_UNIMPL   2'h3

// Timing counts: cycles between fetch acceptance and retire, and extraction cycles.
`define SECT_PRE_CYC      3'h4
`define SECT_HALF_CYC     3'h3
`define SECT_BYTE_CYC     3'h4

// Vectors and address masking.
`define SECT_RESET_PC     32'h00000000
`define SECT_EXC_VECTOR   32'h00000020
`define SECT_ADDR_MASK    32'h7fffffff

`endif

// ==== sect_shifter.v ====
// Serial shifter: moves its operand one bit position per clock.
// Assumes the sequencer loads it once per shift instruction and waits for last.
`default_nettype none
`include "sect_defs.vh"

module sect_shifter
(
	// Clock and reset
	input  wire        clock,
	input  wire        rstn,
	// Load request
	input  wire        load,
	input  wire [31:0] value,
	input  wire [4:0]  amount,
	input  wire [1:0]  kind,
	// Status and result
	output wire        busy,
	output wire        last,
	output wire [31:0] result
);

	reg [31:0] val_reg;
	reg [31:0] val_next;
	reg [4:0]  cnt_reg;
	reg [1:0]  kind_reg;
	reg        busy_reg;

	assign busy   = busy_reg;
	assign last   = busy_reg && (cnt_reg == 5'h00);
	assign result = val_reg;

	always @*
	begin
		case (kind_reg)
			`SECT_SH_SLL: val_next = {val_reg[30:0], 1'b0};
			`SECT_SH_SRL: val_next = {1'b0, val_reg[31:1]};
			`SECT_SH_SRA: val_next = {val_reg[31], val_reg[31:1]};
			default:      val_next = {val_reg[30:0], val_reg[31]};
		endcase
	end

	// One bit moves in each busy cycle but the last, in which the count is zero and nothing moves.
	always @(posedge clock)
	begin
		if (!rstn)
		begin
			val_reg  <= 32'h00000000;
			cnt_reg  <= 5'h00;
			kind_reg <= 2'h0;
			busy_reg <= 1'b0;
		end
		else if (load)
		begin
			val_reg  <= value;
			cnt_reg  <= amount;
			kind_reg <= kind;
			busy_reg <= 1'b1;
		end
		else if (busy_reg)
		begin
			if (cnt_reg == 5'h00)
				busy_reg <= 1'b0;
			else
			begin
				val_reg <= val_next;
				cnt_reg <= cnt_reg - 5'h01;
			end
		end
	end

endmodule // sect_shifter
`default_nettype wire

// ==== sect_bus_model.sv ====
// Bus model of the memories behind the core's instruction and data master ports.
// Assumes the bench sets the fetched word and the wait counts between transfers.
`default_nettype none

module sect_bus_model
#(
	parameter logic [31:0] DVAL = 32'h12345680
)
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// Contents and wait settings from the bench
	input  wire logic [31:0] instr,
	input  wire logic [3:0]  iwait,
	input  wire logic [3:0]  dwait,
	// Instruction port
	input  wire logic        ibus_read,
	output logic             ibus_waitrequest,
	output logic [31:0]      ibus_readdata,
	// Data port
	input  wire logic        dbus_req,
	output logic             dbus_waitrequest,
	output logic [31:0]      dbus_readdata
);
	logic [3:0]  icnt_reg;
	logic [3:0]  dcnt_reg;
	logic [31:0] ilast_reg;

	// A zero wait count answers in the first request cycle, which the six-cycle minimum needs.
	assign ibus_waitrequest = ibus_read && (icnt_reg < iwait);
	assign dbus_waitrequest = dbus_req && (dcnt_reg < dwait);
	// Outside an accepted cycle the data is garbage, so a late sample cannot pass by luck.
	assign ibus_readdata = (ibus_read && !ibus_waitrequest) ? instr : ~ilast_reg;
	assign dbus_readdata = (dbus_req && !dbus_waitrequest) ? DVAL : ~DVAL;

	always @(posedge clock)
	begin
		icnt_reg <= (rstn && ibus_read && ibus_waitrequest) ? icnt_reg + 4'h1 : 4'h0;
		dcnt_reg <= (rstn && dbus_req && dbus_waitrequest) ? dcnt_reg + 4'h1 : 4'h0;
		if (!rstn || (ibus_read && !ibus_waitrequest))
			ilast_reg <= rstn ? instr : 32'h0;
	end
endmodule // sect_bus_model

`default_nettype wire

// ==== sect_timing_assertions.sv ====
// Port checker for the sequential core timing block.
// Assumes one clock with synchronous active-low reset; bound to the core below.
`default_nettype none
`include "sect_defs.vh"

module sect_timing_assertions
(
	// Clock and reset
	input wire logic        clock,
	input wire logic        rstn,
	// Instruction port
	input wire logic        ibus_read,
	input wire logic [31:0] ibus_address,
	input wire logic        ibus_waitrequest,
	input wire logic [31:0] ibus_readdata,
	// Data port
	input wire logic        dbus_read,
	input wire logic        dbus_write,
	input wire logic [31:0] dbus_address,
	input wire logic        dbus_waitrequest,
	// Status
	input wire logic [31:0] instr_word,
	input wire logic        exc_valid,
	input wire logic [1:0]  exc_cause
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	wire       iacc = ibus_read && !ibus_waitrequest;
	wire       dacc = (dbus_read || dbus_write) && !dbus_waitrequest;
	wire [3:0] cls  = instr_word[3:0];
	wire [3:0] fcls = ibus_readdata[3:0];

	addr_msb_a: assert property ((dbus_read || dbus_write) |-> !dbus_address[31])
		else $error("data address bit 31 set");
	one_port_a: assert property (!(ibus_read && (dbus_read || dbus_write)))
		else $error("fetch overlaps data transfer");
	fetch_hold_a: assert property (ibus_read && ibus_waitrequest |=> ibus_read && $stable(ibus_address))
		else $error("fetch dropped while stalled");
	data_hold_a: assert property (dbus_read && dbus_waitrequest |=> dbus_read && $stable(dbus_address))
		else $error("read dropped while stalled");
	fetch_gap_a: assert property (iacc |=> !ibus_read [*5])
		else $error("fetch sooner than six cycles");
	six_cycle_a: assert property (iacc && fcls inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'ha, 4'hc}
		|-> ##6 ibus_read)
		else $error("six-cycle instruction too long");
	ldw_end_a: assert property (dacc && cls == `SECT_CL_LDW |=> !ibus_read ##1 ibus_read)
		else $error("word load end wrong");
	ldh_end_a: assert property (dacc && cls == `SECT_CL_LDH |=> !ibus_read [*4] ##1 ibus_read)
		else $error("halfword load end wrong");
	ldb_end_a: assert property (dacc && cls == `SECT_CL_LDB |=> !ibus_read [*5] ##1 ibus_read)
		else $error("byte load end wrong");
	st_end_a: assert property (dacc && cls == `SECT_CL_STORE |=> !ibus_read ##1 ibus_read)
		else $error("store end wrong");
	exc_vec_a: assert property (exc_valid |-> ibus_read && ibus_address == `SECT_EXC_VECTOR
		&& exc_cause != 2'h0)
		else $error("exception not sent to vector");
endmodule // sect_timing_assertions

bind sect_core_timing sect_timing_assertions i_sect_timing_assertions (.clock, .rstn,
	.ibus_read, .ibus_address, .ibus_waitrequest, .ibus_readdata, .dbus_read, .dbus_write,
	.dbus_address, .dbus_waitrequest, .instr_word, .exc_valid, .exc_cause);

`default_nettype wire

// ==== test_sequential_economy_cpu_timing.sv ====
// Self-checking bench for the sequential core timing block.
// Assumes the bus model file and the checker file are compiled before it.
`default_nettype none
`include "sect_defs.vh"

module test_sequential_economy_cpu_timing;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'b0;
	logic        rstn = 1'b0;
	logic [31:0] instr = 32'h0;
	logic [3:0]  iwait = 4'h0;
	logic [3:0]  dwait = 4'h0;
	logic [31:0] op_a = 32'h100;
	logic [31:0] op_b = 32'h0;
	logic        irq = 1'b0;
	logic [7:0]  ci_lat = 8'h1;
	logic [7:0]  ci_cnt = 8'hff;
	logic [31:0] gap = 32'h0;
	logic [31:0] cnt = 32'h0;
	logic [31:0] acc_addr, d_addr, wb_seen;
	logic [2:0]  exc_seen;
	logic [3:0]  be_seen;
	logic [31:0] wd_seen;
	int          n_fetch = 0;
	int          n_errors = 0;
	int          num_checks = 0;
	wire         ibus_read, ibus_waitrequest, dbus_read, dbus_write, dbus_waitrequest;
	wire [31:0]  ibus_address, ibus_readdata, dbus_address, dbus_readdata, wb_data;
	wire         retire, wb_en, ci_start, exc_valid;
	wire [3:0]   dbus_byteenable;
	wire [31:0]  dbus_writedata;
	wire [1:0]   exc_cause;
	wire         acc = ibus_read & ~ibus_waitrequest;

	sect_core_timing i_sect_core_timing (.clock, .rstn, .ibus_read, .ibus_address,
		.ibus_waitrequest, .ibus_readdata, .dbus_read, .dbus_write, .dbus_address,
		.dbus_byteenable, .dbus_writedata, .dbus_waitrequest, .dbus_readdata,
		.instr_word(), .op_a, .op_b, .retire, .wb_en, .wb_data, .ci_start,
		.ci_done(ci_cnt == ci_lat), .ci_result(32'h0), .irq, .irq_enable(irq), .exc_valid,
		.exc_cause, .exc_return(), .dbg_halt_req(1'b0), .dbg_halted());
	sect_bus_model i_sect_bus_model (.clock, .rstn, .instr, .iwait, .dwait, .ibus_read,
		.ibus_waitrequest, .ibus_readdata, .dbus_req(dbus_read | dbus_write),
		.dbus_waitrequest, .dbus_readdata);

	always #10 clock = ~clock;

	// The custom logic answers a set number of cycles after each start pulse.
	always @(posedge clock)
	begin
		ci_cnt <= #1 ci_start ? 8'h1 : ci_cnt + 8'h1;
		cnt <= acc ? 32'h1 : cnt + 32'h1;
		if (acc)
			gap <= cnt;
		if (acc)
			acc_addr <= ibus_address;
		if (acc)
			n_fetch <= n_fetch + 1;
		if (retire)
			exc_seen <= {exc_valid, exc_cause};
		if (retire && wb_en)
			wb_seen <= wb_data;
		if (dbus_read || dbus_write)
		begin
			d_addr  <= dbus_address;
			be_seen <= dbus_byteenable;
			wd_seen <= dbus_writedata;
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wait_acc();
		int k = n_fetch;
		for (int i = 0; i < 300 && n_fetch == k; i++)
			@(posedge clock) #1;
	endtask

	// Feeds one instruction between two plain ones and measures fetch to fetch.
	task automatic run(input logic [31:0] w, input logic [3:0] fw, input logic [3:0] tw,
		input logic q, input logic [31:0] exp);
		wait_acc();
		instr = w;
		wait_acc();
		instr = 32'h0;
		iwait = fw;
		dwait = tw;
		irq = q;
		wait_acc();
		iwait = 4'h0;
		dwait = 4'h0;
		irq = 1'b0;
		chk("gap", gap, exp);
	endtask

	initial
	begin
		repeat (5) @(posedge clock);
		#1 rstn = 1'b1;
		run(32'h0, 4'h0, 4'h0, 1'b0, 32'd6);
		run(32'h0, 4'h3, 4'h0, 1'b0, 32'd9);
		run(32'h1, 4'h0, 4'h0, 1'b0, 32'd6);
		run(32'hc, 4'h0, 4'h0, 1'b0, 32'd6);
		run(32'ha, 4'h0, 4'h0, 1'b0, 32'd6);
		run(32'h2, 4'h0, 4'h0, 1'b0, 32'd6);
		chk("target", acc_addr, 32'h100);
		run(32'h5, 4'h0, 4'h2, 1'b0, 32'd9);
		run(32'h6, 4'h0, 4'h0, 1'b0, 32'd10);
		run(32'h7, 4'h0, 4'h1, 1'b0, 32'd12);
		chk("byte", wb_seen, 32'hffffff80);
		chk("byte_be", be_seen, 32'h1);
		op_a = 32'hffffff00;
		op_b = 32'ha5;
		run(32'h8, 4'h0, 4'h0, 1'b0, 32'd7);
		chk("daddr", d_addr, 32'h7fffff00);
		chk("store_be", be_seen, 32'hf);
		chk("wdata", wd_seen, 32'ha5);
		op_a = 32'h100;
		op_b = 32'h1f;
		run(32'h9, 4'h0, 4'h0, 1'b0, 32'd38);
		op_b = 32'h0;
		run(32'h9, 4'h0, 4'h0, 1'b0, 32'd7);
		run(32'h3, 4'h0, 4'h0, 1'b0, 32'd6);
		chk("trap", exc_seen, {1'b1, `SECT_EXC_TRAP});
		chk("vector", acc_addr, `SECT_EXC_VECTOR);
		run(32'h4, 4'h0, 4'h0, 1'b0, 32'd6);
		chk("unimpl", exc_seen, {1'b1, `SECT_EXC_UNIMPL});
		run(32'h0, 4'h0, 4'h0, 1'b1, 32'd6);
		chk("irq", exc_seen, {1'b1, `SECT_EXC_IRQ});
		run(32'hb, 4'h0, 4'h0, 1'b0, 32'd6);
		ci_lat = 8'ha;
		run(32'hb, 4'h0, 4'h0, 1'b0, 32'd13);
		test_done();
	end

	initial
	begin
		#100000;
		n_errors++;
		test_done();
	end

	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
endmodule // test_sequential_economy_cpu_timing

`default_nettype wire
